// *** logic/iopab_top.sv ***
// Port A/B pin logic: direction, output data, pin levels, keyboard pin takeover, pull-ups.
// Assumes an Avalon-MM master on CORE_CLK and keyboard controller outputs on the same clock.
//
// How it works
// - PA4 plain I/O by direction; with channel 1 keyboard enabled, drives ch1 clock.
// - PA4 open-drain when channel 1 enabled or bus select set; inputs always readable.
// - PA3 plain I/O by direction; with channel 0 enabled, drives ch0 data.
// - PA3 open-drain only while channel 0 enabled; inputs always available.
// - PA2 plain I/O; with channel 0 enabled drives ch0 clock open-drain; inputs usable.
// - PA1 and PA0 use only their direction bit; key-sense always usable.
// - Port A pull-up on only when pin is input and its output-data bit is one.
// - Pull-ups on PA7 to PA4 off while bus select is set.
// - Pull-up off on any PA7 to PA2 pin held by the keyboard function.
// - All port A pull-ups off in reset and hardware standby.
// - Port B direction one means output; write-only, resets to zero.
// - Port B direction shares its address with pin levels; reads return pins.
// - Port B output data always readable and writable, resets to zero.
// - Port B pin-level read returns present pin levels.
// - Write to pin-level address loads the direction register instead.
// - PB7 to PB2 use only direction bit; wake-up inputs always usable.
// - Port A direction one is output; ignored while keyboard function holds pin.
`timescale 1ns/1ps
`include "iopab_cfg.svh"
module iopab_top
	import iopab_pkg::*;
(
	input  wire logic        CORE_CLK,
	input  wire logic        RST_N,
	input  wire logic [7:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	input  wire logic [7:0]  PA_IN,
	output logic      [7:0]  PA_OUT,
	output logic      [7:0]  PA_OE,
	output logic      [7:0]  PA_PULLUP,
	input  wire logic [7:0]  PB_IN,
	output logic      [7:0]  PB_OUT,
	output logic      [7:0]  PB_OE,
	input  wire logic        KBD_CH0_CLOCK,
	input  wire logic        KBD_CH0_DATA,
	input  wire logic        KBD_CH1_CLOCK,
	input  wire logic        KBD_CH1_DATA,
	input  wire logic        KBD_CH2_CLOCK,
	input  wire logic        KBD_CH2_DATA,
	output logic      [7:0]  KEY_SENSE,
	output logic      [7:2]  WAKEUP_EVENT
);
	iopab_bus_st_t st_q;
	iopab_bus_st_t st_d;
	logic [7:0]    pa_dir_q;
	logic [7:0]    pa_odr_q;
	logic [7:0]    pb_dir_q;
	logic [7:0]    pb_odr_q;
	logic [7:0]    ctrl_q;
	logic [15:0]   pins;
	logic [7:0]    pa_pins;
	logic [7:0]    pb_pins;
	logic          wr_go;
	logic [7:0]    wdata;
	logic [7:0]    rd_byte;
	logic [2:0]    kbd_en;
	logic          bus_sel;
	iopab_mode_t   mode;
	logic [7:0]    pa_kbd;
	logic [7:0]    pa_kbd_val;
	logic [7:0]    pa_od;
	logic [7:0]    pa_val;
	logic [7:0]    pa_drv;
	logic [7:0]    pa_oe_d;
	logic [7:0]    pa_out_d;
	logic [7:0]    pa_pu_d;

	// Register next value: load the write byte on a hit, otherwise hold
	function automatic logic [7:0] upd8(input logic [7:0] cur, input logic hit, input logic [7:0] d);
		upd8 = hit ? d : cur;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchroniser; its filtered levels feed reads, key-sense and wake-up
	iopab_sync u_sync (
		.clk   (CORE_CLK),
		.rst_n (RST_N),
		.raw   ({PB_IN, PA_IN}),
		.level (pins)
	);

	assign pa_pins = pins[7:0];
	assign pb_pins = pins[15:8];
	assign KEY_SENSE = pa_pins;
	assign WAKEUP_EVENT = pb_pins[7:2];

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode; only byte lane 0 carries register data, upper lanes read zero
	assign wr_go = (st_q == IOPAB_ST_ACK) && AVS_WRITE && AVS_BYTEENABLE[0];
	assign wdata = AVS_WRITEDATA[7:0];
	assign st_d = ((st_q == IOPAB_ST_IDLE) && (AVS_READ || AVS_WRITE)) ? IOPAB_ST_ACK : IOPAB_ST_IDLE;

	// Direction registers are write-only: their address returns the pins
	assign rd_byte = (AVS_ADDRESS == `IOPAB_OFS_PA_DIR) ? pa_pins :
	                 (AVS_ADDRESS == `IOPAB_OFS_PA_ODR) ? pa_odr_q :
	                 (AVS_ADDRESS == `IOPAB_OFS_PB_DIR) ? pb_pins :
	                 (AVS_ADDRESS == `IOPAB_OFS_PB_ODR) ? pb_odr_q :
	                 (AVS_ADDRESS == `IOPAB_OFS_CTRL)   ? ctrl_q : 8'h00;

	// Two-cycle handshake: every access, mapped or not, answers after one wait cycle
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			st_q            <= IOPAB_ST_IDLE;
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA    <= `IOPAB_RST_RDATA;
		end else begin
			st_q            <= st_d;
			AVS_WAITREQUEST <= (st_d != IOPAB_ST_ACK);
			if ((st_q == IOPAB_ST_IDLE) && AVS_READ) begin
				AVS_READDATA <= {24'h000000, rd_byte};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register file; a write to a pin-level address lands in the direction register
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			pa_dir_q <= `IOPAB_RST_DIR;
			pa_odr_q <= `IOPAB_RST_ODR;
			pb_dir_q <= `IOPAB_RST_DIR;
			pb_odr_q <= `IOPAB_RST_ODR;
			ctrl_q   <= `IOPAB_RST_CTRL;
		end else begin
			pa_dir_q <= upd8(pa_dir_q, wr_go && (AVS_ADDRESS == `IOPAB_OFS_PA_DIR), wdata);
			pa_odr_q <= upd8(pa_odr_q, wr_go && (AVS_ADDRESS == `IOPAB_OFS_PA_ODR), wdata);
			pb_dir_q <= upd8(pb_dir_q, wr_go && (AVS_ADDRESS == `IOPAB_OFS_PB_DIR), wdata);
			pb_odr_q <= upd8(pb_odr_q, wr_go && (AVS_ADDRESS == `IOPAB_OFS_PB_ODR), wdata);
			ctrl_q   <= upd8(ctrl_q, wr_go && (AVS_ADDRESS == `IOPAB_OFS_CTRL), wdata);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control fields
	assign kbd_en  = {ctrl_q[`IOPAB_CTL_KBD_CH2], ctrl_q[`IOPAB_CTL_KBD_CH1], ctrl_q[`IOPAB_CTL_KBD_CH0]};
	assign bus_sel = ctrl_q[`IOPAB_CTL_BUS_SEL];
	assign mode    = iopab_mode_t'(ctrl_q[`IOPAB_CTL_MODE_MSB:`IOPAB_CTL_MODE_LSB]);

	// Keyboard takeover per pin pair: PA7/6 ch2, PA5/4 ch1, PA3/2 ch0; data above clock
	assign pa_kbd     = {{2{kbd_en[2]}}, {2{kbd_en[1]}}, {2{kbd_en[0]}}, 2'b00};
	assign pa_kbd_val = {KBD_CH2_DATA, KBD_CH2_CLOCK, KBD_CH1_DATA, KBD_CH1_CLOCK,
	                     KBD_CH0_DATA, KBD_CH0_CLOCK, 2'b00};

	// Bus select turns only the upper nibble open-drain; PA3/PA2 follow keyboard alone
	assign pa_od = pa_kbd | {{4{bus_sel}}, 4'h0};

	// Keyboard takeover overrides the direction bit; plain outputs carry output data
	assign pa_val = (pa_kbd & pa_kbd_val) | (~pa_kbd & pa_odr_q);
	assign pa_drv = pa_kbd | pa_dir_q;

	// Open-drain pins only sink: enable while the value is low, never drive high
	assign pa_oe_d  = pa_drv & (~pa_od | ~pa_val);
	assign pa_out_d = pa_val & ~pa_od;

	// Pull-up: input with data one, not taken by keyboard or bus select, not in hardware standby
	assign pa_pu_d = ~pa_dir_q & pa_odr_q
	               & ~pa_kbd
	               & ~{{4{bus_sel}}, 4'h0}
	               & {8{mode != IOPAB_MODE_HW_STBY}};

	////////////////////////////////////////////////////////////////////////////////
	// Pin drivers are registered so every output starts from a flop; costs one cycle
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			PA_OUT    <= 8'h00;
			PA_OE     <= 8'h00;
			PA_PULLUP <= 8'h00;
			PB_OUT    <= 8'h00;
			PB_OE     <= 8'h00;
		end else begin
			PA_OUT    <= pa_out_d;
			PA_OE     <= pa_oe_d;
			PA_PULLUP <= pa_pu_d;
			PB_OUT    <= pb_odr_q;
			PB_OE     <= pb_dir_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_N);

	AST_PB_DIR_DRIVES_OE: assert property ($past(RST_N) |-> PB_OE == $past(pb_dir_q))
		else $error("port B enable does not follow direction");
	AST_PB_OUT_FOLLOWS_ODR: assert property ($past(RST_N) |-> PB_OUT == $past(pb_odr_q))
		else $error("port B output does not follow output data");
	AST_PB_DIR_RESET: assert property (!$past(RST_N) |-> pb_dir_q == 8'h00 && pb_odr_q == 8'h00)
		else $error("port B registers not cleared by reset");
	AST_PB_DIR_READS_PINS: assert property (
		(AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == `IOPAB_OFS_PB_DIR)
		|-> AVS_READDATA == {24'h000000, $past(pb_pins)})
		else $error("direction address did not return pin levels");
	AST_PIN_WRITE_LOADS_DIR: assert property (
		(AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0] && AVS_ADDRESS == `IOPAB_OFS_PB_DIR)
		|=> pb_dir_q == $past(AVS_WRITEDATA[7:0]) ##1 PB_OE == $past(AVS_WRITEDATA[7:0], 2))
		else $error("pin-level write did not load direction");
	AST_PB_ODR_WRITE: assert property (
		(AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0] && AVS_ADDRESS == `IOPAB_OFS_PB_ODR)
		|=> pb_odr_q == $past(AVS_WRITEDATA[7:0]))
		else $error("output data write lost");
	AST_ACK_ONE_CYCLE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("waitrequest low for more than one cycle");
	AST_PA4_KBD_CLOCK: assert property (kbd_en[1] |=> !PA_OUT[4] && PA_OE[4] == !$past(KBD_CH1_CLOCK))
		else $error("PA4 not driving channel 1 clock open-drain");
	AST_PA4_BUS_SEL_OD: assert property (bus_sel && pa_dir_q[4] && !kbd_en[1] |=> !PA_OUT[4])
		else $error("PA4 drives high while bus select set");
	AST_PA3_KBD_DATA: assert property (kbd_en[0] |=> !PA_OUT[3] && PA_OE[3] == !$past(KBD_CH0_DATA))
		else $error("PA3 not driving channel 0 data open-drain");
	AST_PA3_PUSH_PULL: assert property (!kbd_en[0] && pa_dir_q[3] |=> PA_OE[3] && PA_OUT[3] == $past(pa_odr_q[3]))
		else $error("PA3 not push-pull while keyboard off");
	AST_PA2_KBD_CLOCK: assert property (kbd_en[0] && !pa_dir_q[2] && !KBD_CH0_CLOCK |=> PA_OE[2] && !PA_OUT[2])
		else $error("PA2 keyboard clock low not driven");
	AST_PA_LOW_DIR_ONLY: assert property ($past(RST_N) |-> PA_OE[1:0] == $past(pa_dir_q[1:0]))
		else $error("PA1/PA0 enable not from direction");
	AST_PA_PULLUP_RULE: assert property (mode != IOPAB_MODE_HW_STBY
		|=> PA_PULLUP[1:0] == $past(~pa_dir_q[1:0] & pa_odr_q[1:0]))
		else $error("PA1/PA0 pull-up wrong");
	AST_PA_PULLUP_BUS_SEL: assert property (bus_sel |=> PA_PULLUP[7:4] == 4'h0)
		else $error("upper pull-ups on with bus select");
	AST_PA_PULLUP_KBD: assert property (kbd_en[2] |=> PA_PULLUP[7:6] == 2'b00)
		else $error("pull-up on under keyboard function");
	AST_PA_PULLUP_HW_STBY: assert property (mode == IOPAB_MODE_HW_STBY |=> PA_PULLUP == 8'h00)
		else $error("pull-up on in hardware standby");
	AST_PA_DIR_IGNORED: assert property (kbd_en[1] && !pa_dir_q[5] && !KBD_CH1_DATA |=> PA_OE[5])
		else $error("keyboard pin blocked by direction bit");

	// Reset must leave port B drivers and port A pull-ups released on the first edge out of it
	AST_PA_PULLUP_RESET: assert property (!$past(RST_N)
		|-> PA_PULLUP == 8'h00)
		else $error("pull-up on right after reset");
	AST_PB_OE_RESET: assert property (!$past(RST_N)
		|-> PB_OE == 8'h00 && PB_OUT == 8'h00)
		else $error("port B drivers on right after reset");

	// Pull-up terms one by one, so a dropped term shows up as a stray pull-up
	AST_PA_PULLUP_NOT_OUTPUT: assert property ($past(RST_N)
		|-> (PA_PULLUP & $past(pa_dir_q)) == 8'h00)
		else $error("pull-up on an output pin");
	AST_PA_PULLUP_DATA_ONE: assert property ($past(RST_N)
		|-> (PA_PULLUP & ~$past(pa_odr_q)) == 8'h00)
		else $error("pull-up on with output data zero");
	AST_PA_PULLUP_UPPER: assert property (!bus_sel && !kbd_en[2] && mode != IOPAB_MODE_HW_STBY
		|=> PA_PULLUP[7:6] == $past(~pa_dir_q[7:6] & pa_odr_q[7:6]))
		else $error("PA7/PA6 pull-up wrong");
	AST_PA_PULLUP_CH0: assert property (kbd_en[0]
		|=> PA_PULLUP[3:2] == 2'b00)
		else $error("PA3/PA2 pull-up on under keyboard function");
	AST_PA_PULLUP_CH1: assert property (kbd_en[1]
		|=> PA_PULLUP[5:4] == 2'b00)
		else $error("PA5/PA4 pull-up on under keyboard function");

	// Upper keyboard pins sink only while the controller pulls low; direction plays no part
	AST_PA5_KBD_DATA: assert property (kbd_en[1]
		|=> !PA_OUT[5] && PA_OE[5] == !$past(KBD_CH1_DATA))
		else $error("PA5 not driving channel 1 data open-drain");
	AST_PA6_KBD_CLOCK: assert property (kbd_en[2]
		|=> !PA_OUT[6] && PA_OE[6] == !$past(KBD_CH2_CLOCK))
		else $error("PA6 not driving channel 2 clock open-drain");
	AST_PA7_KBD_DATA: assert property (kbd_en[2]
		|=> !PA_OUT[7] && PA_OE[7] == !$past(KBD_CH2_DATA))
		else $error("PA7 not driving channel 2 data open-drain");

	// PA4 to PA0 outside keyboard use and PA2 clock release; bus select reaches PA4 but never PA3
	AST_PA4_PLAIN_OUT: assert property (!kbd_en[1] && !bus_sel && pa_dir_q[4]
		|=> PA_OE[4] && PA_OUT[4] == $past(pa_odr_q[4]))
		else $error("PA4 plain output wrong");
	AST_PA4_PLAIN_IN: assert property (!kbd_en[1] && !pa_dir_q[4]
		|=> !PA_OE[4])
		else $error("PA4 drives while an input");
	AST_PA4_BUS_SEL_SINK: assert property (bus_sel && !kbd_en[1]
		|=> PA_OE[4] == $past(pa_dir_q[4] && !pa_odr_q[4]))
		else $error("PA4 open-drain enable wrong under bus select");
	AST_PA3_BUS_SEL_PUSH_PULL: assert property (bus_sel && !kbd_en[0] && pa_dir_q[3]
		|=> PA_OE[3] && PA_OUT[3] == $past(pa_odr_q[3]))
		else $error("PA3 made open-drain by bus select");
	AST_PA2_PLAIN: assert property (!kbd_en[0]
		|=> PA_OE[2] == $past(pa_dir_q[2]))
		else $error("PA2 enable not from direction");
	AST_PA2_KBD_RELEASE: assert property (kbd_en[0] && KBD_CH0_CLOCK
		|=> !PA_OE[2] && !PA_OUT[2])
		else $error("PA2 drives while channel 0 clock released");
	AST_PA_LOW_OUT: assert property ($past(RST_N)
		|-> PA_OUT[1:0] == $past(pa_odr_q[1:0]))
		else $error("PA1/PA0 output not from output data");

	// Register side effects: output data reads back, a write without lane 0 changes nothing
	AST_PB_ODR_READ: assert property (
		AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == `IOPAB_OFS_PB_ODR
		|-> AVS_READDATA == {24'h000000, $past(pb_odr_q)})
		else $error("output data read back wrong");
	AST_BE_OFF_NO_WRITE: assert property (AVS_WRITE && !AVS_WAITREQUEST && !AVS_BYTEENABLE[0]
		|=> $stable(pb_odr_q) && $stable(pb_dir_q))
		else $error("write without byte lane 0 changed a register");
endmodule

// *** logic/iopab_cfg.svh ***
// Register offsets, field positions and reset values of the port A/B pin logic.
// Assumes byte addresses on a 32-bit Avalon-MM slave, one aligned word per register.
`ifndef IOPAB_CFG_SVH
`define IOPAB_CFG_SVH
////////////////////////////////////////////////////////////////////////////////
// Byte offsets
`define IOPAB_OFS_PA_DIR   8'h00
`define IOPAB_OFS_PA_ODR   8'h04
`define IOPAB_OFS_PB_DIR   8'h08
`define IOPAB_OFS_PB_ODR   8'h0C
`define IOPAB_OFS_CTRL     8'h10
////////////////////////////////////////////////////////////////////////////////
// Control register fields
`define IOPAB_CTL_KBD_CH0  0
`define IOPAB_CTL_KBD_CH1  1
`define IOPAB_CTL_KBD_CH2  2
`define IOPAB_CTL_BUS_SEL  3
`define IOPAB_CTL_MODE_LSB 4
`define IOPAB_CTL_MODE_MSB 5
////////////////////////////////////////////////////////////////////////////////
// Reset values
`define IOPAB_RST_DIR      8'h00
`define IOPAB_RST_ODR      8'h00
`define IOPAB_RST_CTRL     8'h00
`define IOPAB_RST_RDATA    32'h0000_0000
`endif

// *** logic/iopab_pkg.sv ***
// Types shared by the port A/B pin logic.
// Assumes nothing beyond a SystemVerilog compiler.
package iopab_pkg;
	// Bus handshake states, one-hot
	typedef enum logic [1:0] {
		IOPAB_ST_IDLE = 2'b01,
		IOPAB_ST_ACK  = 2'b10
	} iopab_bus_st_t;

	// Operating mode as seen by the pull-up control
	typedef enum logic [1:0] {
		IOPAB_MODE_NORMAL = 2'b00,
		IOPAB_MODE_SW_STBY = 2'b01,
		IOPAB_MODE_HW_STBY = 2'b10,
		IOPAB_MODE_SPARE = 2'b11
	} iopab_mode_t;
endpackage

// *** logic/iopab_sync.sv ***
// Three-stage pin synchroniser with agreement filter for the sixteen port pins.
// Assumes raw pin levels from outside the CORE_CLK domain.
`timescale 1ns/1ps
module iopab_sync
	import iopab_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [15:0] raw,
	output logic      [15:0] level
);
	logic [15:0] s1_q;
	logic [15:0] s2_q;
	logic [15:0] s3_q;
	logic [15:0] level_d;

	////////////////////////////////////////////////////////////////////////////////
	// A bit moves only once stages two and three agree, hiding a late settle
	assign level_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & level);

	// First stage feeds the second only
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_q  <= 16'h0000;
			s2_q  <= 16'h0000;
			s3_q  <= 16'h0000;
			level <= 16'h0000;
		end else begin
			s1_q  <= raw;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			level <= level_d;
		end
	end
endmodule

// *** dv/iopab_pin_model.sv ***
// Pin model for ports A and B: resolves each pad from the block's drive, pull-up and an outside source.
// Assumes the outside source is weak: the block's driver or pull-up wins over it.
`timescale 1ns/1ps
module iopab_pin_model (
	input  wire logic [7:0] pa_out,
	input  wire logic [7:0] pa_oe,
	input  wire logic [7:0] pa_pullup,
	input  wire logic [7:0] pb_out,
	input  wire logic [7:0] pb_oe,
	input  wire logic [7:0] ext_a,
	input  wire logic [7:0] ext_b,
	output logic      [7:0] pa_in,
	output logic      [7:0] pb_in
);
	////////////////////////////////////////////////////////////////////////
	// Pad levels; port B has no pull-up here, so undriven pins take the outside level
	assign pa_in = (pa_oe & pa_out) | (~pa_oe & (pa_pullup | ext_a));
	assign pb_in = (pb_oe & pb_out) | (~pb_oe & ext_b);
endmodule

// *** dv/tb_io_port_a_b_pin_logic.sv ***
// Self-checking bench for the port A/B pin logic: Avalon master, pin checks, read scoreboard.
// Assumes iopab_top and iopab_pin_model are compiled before it.
`timescale 1ns/1ps
`include "iopab_cfg.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
	$display("MISMATCH t=%0t act=%h exp=%h", $time, a, e); end end
module tb_io_port_a_b_pin_logic
	import iopab_pkg::*;
;
	logic        clk, rst_n, rd, wr, wait_r;
	logic [7:0]  addr, ext_a, ext_b, pa_out, pa_oe, pa_pu, pb_out, pb_oe, ks, pa_in, pb_in;
	logic [7:0]  dir, odr, ctl, oe, po, pu, lv, pbd, pbo, pbl, kb, bs, r;
	logic [7:2]  wk;
	logic [5:0]  kbd;
	logic [31:0] wdata, rdata, ev;
	logic [3:0]  be;
	logic [15:0] seed;
	logic [31:0] exp_q[$];
	int          bad_count, cmp_count, i;
	////////////////////////////////////////////////////////////////////////////
	iopab_top dut (.CORE_CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_r),
		.PA_IN(pa_in), .PA_OUT(pa_out), .PA_OE(pa_oe), .PA_PULLUP(pa_pu), .PB_IN(pb_in),
		.PB_OUT(pb_out), .PB_OE(pb_oe), .KBD_CH0_CLOCK(kbd[0]), .KBD_CH0_DATA(kbd[1]),
		.KBD_CH1_CLOCK(kbd[2]), .KBD_CH1_DATA(kbd[3]), .KBD_CH2_CLOCK(kbd[4]), .KBD_CH2_DATA(kbd[5]),
		.KEY_SENSE(ks), .WAKEUP_EVENT(wk));
	iopab_pin_model pins (.pa_out(pa_out), .pa_oe(pa_oe), .pa_pullup(pa_pu), .pb_out(pb_out),
		.pb_oe(pb_oe), .ext_a(ext_a), .ext_b(ext_b), .pa_in(pa_in), .pb_in(pb_in));
	////////////////////////////////////////////////////////////////////////////
	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// LFSR source of all random stimulus
	function automatic logic [7:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed[7:0];
	endfunction
	task automatic end_sim();
		// A read that was noted but never answered is a failure too
		if (exp_q.size() != 0) bad_count++;
		if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// One bus cycle; the request holds until waitrequest is seen low on a rising edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		addr <= a;
		wdata <= {24'h0, d};
		wr <= w;
		rd <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (wait_r !== 1'b0 && n < 40);
		if (n >= 40) begin
			bad_count++;
			end_sim();
		end
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back({24'h0, e});
		bus(1'b0, a, 8'h00);
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Read scoreboard: the oldest note is matched against data at the accepting edge
	always @(posedge clk) begin
		if (rst_n && rd && wait_r === 1'b0) begin
			if (exp_q.size() == 0) bad_count++;
			else begin
				// Take the note once, so a mismatch report does not pop a second one
				ev = exp_q.pop_front();
				`CHK(rdata, ev)
			end
		end
	end
	// Main sequence; expected pin states are derived from the written settings, keyboard inputs and outside levels
	initial begin
		{rst_n, rd, wr, addr, wdata, ext_a, ext_b, kbd} = '0;
		be = 4'hF;
		seed = 16'h58A5;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		`CHK(pb_oe, 8'h00)
		`CHK(pa_pu, 8'h00)
		rd_chk(`IOPAB_OFS_PB_ODR, 8'h00);
		rd_chk(8'h14, 8'h00);
		for (i = 0; i < 16; i++) begin
			r = rnd();
			dir = rnd();
			odr = rnd();
			pbd = rnd();
			pbo = rnd();
			ctl = {2'b00, i[1:0], (i < 4) ? 4'h0 : r[3:0]};
			bus(1'b1, `IOPAB_OFS_PA_DIR, dir);
			bus(1'b1, `IOPAB_OFS_PA_ODR, odr);
			bus(1'b1, `IOPAB_OFS_CTRL, ctl);
			bus(1'b1, `IOPAB_OFS_PB_DIR, pbd);
			bus(1'b1, `IOPAB_OFS_PB_ODR, pbo);
			r = rnd();
			kbd <= r[5:0];
			ext_a <= rnd();
			ext_b <= rnd();
			// Output register, then three sync stages and the filter
			repeat (6) @(posedge clk);
			kb = {{2{ctl[2]}}, {2{ctl[1]}}, {2{ctl[0]}}, 2'b00};
			bs = ctl[3] ? 8'hF0 : 8'h00;
			oe = (kb & ~{kbd, 2'b00}) | (~kb & ((bs & dir & ~odr) | (~bs & dir)));
			po = ~kb & ~bs & odr;
			pu = ~dir & odr & ~kb & ~bs & {8{ctl[5:4] != IOPAB_MODE_HW_STBY}};
			lv = (oe & po) | (~oe & (pu | ext_a));
			pbl = (pbd & pbo) | (~pbd & ext_b);
			`CHK(pa_oe, oe)
			`CHK(pa_out, po)
			`CHK(pa_pu, pu)
			`CHK(ks, lv)
			`CHK(pb_oe, pbd)
			`CHK(pb_out, pbo)
			`CHK(wk, pbl[7:2])
			rd_chk(`IOPAB_OFS_PA_DIR, lv);
			rd_chk(`IOPAB_OFS_PB_DIR, pbl);
			rd_chk(`IOPAB_OFS_PB_ODR, pbo);
			rd_chk(`IOPAB_OFS_CTRL, ctl);
		end
		// A write without byte 0 enabled must leave the register alone
		be <= 4'h0;
		bus(1'b1, `IOPAB_OFS_PB_ODR, ~pbo);
		be <= 4'hF;
		rd_chk(`IOPAB_OFS_PB_ODR, pbo);
		// Second reset with pull-ups requested: pull-ups, port B enables and port B output data must drop
		bus(1'b1, `IOPAB_OFS_PA_DIR, 8'h00);
		bus(1'b1, `IOPAB_OFS_PA_ODR, 8'hFF);
		bus(1'b1, `IOPAB_OFS_CTRL, 8'h00);
		repeat (2) @(posedge clk);
		`CHK(pa_pu, 8'hFF)
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		`CHK(pa_pu, 8'h00)
		`CHK(pb_oe, 8'h00)
		rst_n <= 1'b1;
		rd_chk(`IOPAB_OFS_PB_ODR, 8'h00);
		repeat (3) @(posedge clk);
		end_sim();
	end
endmodule
